// ===== src/sfcm_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial flow control block
// Assumes: 125 MHz core clock, 32-bit register port with byte offsets
// Notes:   Definitions only; included by bare name
`ifndef SFCM_CFG_SVH
`define SFCM_CFG_SVH

// Register offsets (byte addresses)
`define SFCM_OFF_CONFIG       4'h0
`define SFCM_OFF_STATUS       4'h4
`define SFCM_OFF_SWCMD        4'h8
`define SFCM_OFF_MARKS        4'hc

// Flow code byte values
`define SFCM_CODE_OUTPUT      8'h23
`define SFCM_CODE_INPUT       8'h22

// Output flow config word fields
`define SFCM_CODE_LSB         0
`define SFCM_MODE_LSB         8
`define SFCM_INH_TOD_BIT      11
`define SFCM_INH_RXLEN_BIT    12
`define SFCM_UNIT_BIT         15
`define SFCM_EXT_LSB          24

// Input flow config word fields
`define SFCM_LOW_LSB          12
`define SFCM_HIGH_LSB         22

// Status word fields
`define SFCM_ST_CTS_BIT       0
`define SFCM_ST_CD_BIT        1

// Software command bits
`define SFCM_CMD_SET_BIT      0
`define SFCM_CMD_CLR_BIT      1

// Reset values and highest legal mode
`define SFCM_RST_MODE         3'h0
`define SFCM_RST_EXT          8'h01
`define SFCM_RST_MARK         10'h100
`define SFCM_MAX_MODE         3'h5

// Timing: one normalized character is ten bits at 1200 bps
`define SFCM_CLK_MHZ          125
`define SFCM_NORM_CHAR_US     8334
`define SFCM_NORM_CHAR_CYC    (`SFCM_NORM_CHAR_US * `SFCM_CLK_MHZ)

`endif

// ===== src/sfcm_flow.sv
// Purpose: Modem-control flow logic for an asynchronous serial port
// Assumes: Transmitter and receive buffer run on i_clk; line pins are asynchronous
// Notes:   Six flow modes steer request-to-send and gate transmit and receive
`include "sfcm_cfg.svh"

//////////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Mode 0 forces clear-to-send, carrier-detect internally
// - Mode 0 raises send request per transmit
// - Reset mode 0; software request command selects 1
// - Mode 1: free transfer, software request, readable pins
// - Mode 2: send on clear-to-send, software request
// - Mode 3: always transfer, automatic request per transmit
// - Modes 3,4: software request, deferred clear
// - Mode 4 receives only with carrier-detect
// - Mode 4 waits clear-to-send before sending
// - Mode 5: watermark request, send on clear-to-send
// - Code 0x23 loads mode from bits 10-8
// - Bits 31-24 set turn-off extension, default 1
// - Bit 15 selects normalized 1200 bps unit
// - Bits 12, 11 inhibit length and on-demand
// - Code 0x22 loads high/low watermarks
// - Status shows mode, carrier, clear-to-send
module sfcm_flow
  import sfcm_pkg::*;
#(
  parameter int unsigned NORM_CHAR_CYC = `SFCM_NORM_CHAR_CYC  // Cycles per normalized character
) (
  input  wire logic        i_clk,              // Core clock, 125 MHz
  input  wire logic        i_rst_n,            // Synchronous reset, active low
  input  wire logic [3:0]  i_addr,             // Register byte address
  input  wire logic [31:0] i_wdata,            // Register write data
  input  wire logic        i_we,               // Write strobe
  input  wire logic        i_re,               // Read strobe
  output logic      [31:0] o_rdata,            // Read data, cycle after strobe
  input  wire logic        i_clear_to_send,    // Line pin, asynchronous
  input  wire logic        i_carrier_detect,   // Line pin, asynchronous
  output logic             o_rts,              // Request-to-send pin
  input  wire logic        i_tx_pending,       // Transmit buffer holds data
  input  wire logic        i_tx_stop_done,     // Final stop bit left shifter, pulse
  input  wire logic        i_char_tick,        // One character time at line rate, pulse
  input  wire logic [9:0]  i_rx_fill,          // Receive buffer fill level
  output logic             o_tx_enable,        // Transmitter may send
  output logic             o_rx_enable,        // Receiver may accept data
  output logic             o_inhibit_rxlen,    // Receive buffer length frozen
  output logic             o_inhibit_tod       // Transmit on demand blocked
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]     cts_sync_ff;      // Clear-to-send synchroniser
  logic [1:0]     cd_sync_ff;       // Carrier-detect synchroniser
  logic           cts_s;            // Synchronised clear-to-send
  logic           cd_s;             // Synchronised carrier-detect
  sfcm_cfg_type   cfg_ff;           // Flow configuration
  sfcm_marks_type marks_ff;         // Dynamic mode watermarks
  logic           sw_rts_ff;        // Software request-to-send
  logic           clr_pend_ff;      // Software clear waiting for empty buffer
  logic           wm_rts_ff;        // Watermark request-to-send
  sfcm_state_type state_ff;         // Automatic request sequencer
  sfcm_state_type nxt_state;
  logic [7:0]     ext_left_ff;      // Extension characters left
  logic [31:0]    norm_cnt_ff;      // Normalized character timer
  logic           norm_tick;        // Normalized character expired
  logic           ext_tick;         // Character tick in chosen unit
  logic           auto_rts;         // Sequencer wants request-to-send
  logic           wr_cfg;           // Config word write
  logic           wr_cmd;           // Software command write
  logic           cmd_set;          // Software set request
  logic           cmd_clr;          // Software clear request
  logic [2:0]     new_mode;         // Mode field of write data
  logic           nxt_rts;
  logic           nxt_tx_en;
  logic           nxt_rx_en;
  logic [31:0]    nxt_rdata;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: only the second stage is read by logic

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cts_sync_ff <= 2'h0;
      cd_sync_ff  <= 2'h0;
    end else begin
      cts_sync_ff <= {cts_sync_ff[0], i_clear_to_send};
      cd_sync_ff  <= {cd_sync_ff[0], i_carrier_detect};
    end
  end

  assign cts_s = cts_sync_ff[1];
  assign cd_s  = cd_sync_ff[1];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register port decode

  assign wr_cfg   = i_we && (i_addr == `SFCM_OFF_CONFIG);
  assign wr_cmd   = i_we && (i_addr == `SFCM_OFF_SWCMD);
  assign cmd_set  = wr_cmd && i_wdata[`SFCM_CMD_SET_BIT];
  assign cmd_clr  = wr_cmd && i_wdata[`SFCM_CMD_CLR_BIT];
  assign new_mode = i_wdata[`SFCM_MODE_LSB +: 3];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Flow configuration; reserved fields are not checked, software keeps them zero

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_ff.mode      <= `SFCM_RST_MODE;
      cfg_ff.ext_cnt   <= `SFCM_RST_EXT;
      cfg_ff.ext_unit  <= 1'b0;
      cfg_ff.inh_rxlen <= 1'b0;
      cfg_ff.inh_tod   <= 1'b0;
    end else if (wr_cfg && i_wdata[`SFCM_CODE_LSB +: 8] == `SFCM_CODE_OUTPUT) begin
      // Out-of-range mode numbers leave the mode alone but load other fields
      if (new_mode <= `SFCM_MAX_MODE) begin
        cfg_ff.mode <= new_mode;
      end
      cfg_ff.ext_cnt   <= i_wdata[`SFCM_EXT_LSB +: 8];
      cfg_ff.ext_unit  <= i_wdata[`SFCM_UNIT_BIT];
      cfg_ff.inh_rxlen <= i_wdata[`SFCM_INH_RXLEN_BIT];
      cfg_ff.inh_tod   <= i_wdata[`SFCM_INH_TOD_BIT];
    end else if (wr_cmd && (cmd_set || cmd_clr) && cfg_ff.mode == 3'h0) begin
      // First software request command leaves mode 0 for manual mode
      cfg_ff.mode <= 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Watermarks; zero is outside the legal range and leaves the mark as it was

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      marks_ff.high <= `SFCM_RST_MARK;
      marks_ff.low  <= `SFCM_RST_MARK;
    end else if (wr_cfg && i_wdata[`SFCM_CODE_LSB +: 8] == `SFCM_CODE_INPUT) begin
      if (i_wdata[`SFCM_HIGH_LSB +: 10] != 10'h000) begin
        marks_ff.high <= i_wdata[`SFCM_HIGH_LSB +: 10];
      end
      if (i_wdata[`SFCM_LOW_LSB +: 10] != 10'h000) begin
        marks_ff.low <= i_wdata[`SFCM_LOW_LSB +: 10];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Software request-to-send with deferred clear in modes 3 and 4 while the buffer still holds data

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sw_rts_ff   <= 1'b0;
      clr_pend_ff <= 1'b0;
    end else if (cmd_set) begin
      // A set wins over a clear in the same write
      sw_rts_ff   <= 1'b1;
      clr_pend_ff <= 1'b0;
    end else if (cmd_clr) begin
      if ((cfg_ff.mode == 3'h3 || cfg_ff.mode == 3'h4) && i_tx_pending) begin
        clr_pend_ff <= 1'b1;
      end else begin
        sw_rts_ff   <= 1'b0;
        clr_pend_ff <= 1'b0;
      end
    end else if (clr_pend_ff && !i_tx_pending) begin
      sw_rts_ff   <= 1'b0;
      clr_pend_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Watermark hysteresis for dynamic mode; fill between marks holds the last level

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wm_rts_ff <= 1'b1;
    end else if (i_rx_fill > marks_ff.high) begin
      wm_rts_ff <= 1'b0;
    end else if (i_rx_fill < marks_ff.low) begin
      wm_rts_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Normalized character timer: restarts when the extension starts, so the first
  // normalized character is whole rather than a fragment

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      norm_cnt_ff <= 32'h0;
    end else if (state_ff != SFCM_EXTEND || norm_tick) begin
      norm_cnt_ff <= 32'h0;
    end else begin
      norm_cnt_ff <= norm_cnt_ff + 32'h1;
    end
  end

  assign norm_tick = (norm_cnt_ff == NORM_CHAR_CYC - 32'h1);
  assign ext_tick  = cfg_ff.ext_unit ? norm_tick : i_char_tick;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Automatic request sequencer: idle, sending, then turn-off extension

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SFCM_IDLE: begin
        if (i_tx_pending) begin
          nxt_state = SFCM_SEND;
        end
      end
      SFCM_SEND: begin
        // Extension starts only once the last stop bit has gone
        if (i_tx_stop_done && !i_tx_pending) begin
          nxt_state = (cfg_ff.ext_cnt == 8'h00) ? SFCM_IDLE : SFCM_EXTEND;
        end
      end
      SFCM_EXTEND: begin
        if (i_tx_pending) begin
          nxt_state = SFCM_SEND;
        end else if (ext_tick && ext_left_ff == 8'h01) begin
          nxt_state = SFCM_IDLE;
        end
      end
      default: begin
        nxt_state = SFCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= SFCM_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Extension countdown in characters of the chosen unit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_left_ff <= 8'h00;
    end else if (state_ff != SFCM_EXTEND) begin
      ext_left_ff <= cfg_ff.ext_cnt;
    end else if (ext_tick && ext_left_ff != 8'h00) begin
      ext_left_ff <= ext_left_ff - 8'h01;
    end
  end

  assign auto_rts = (state_ff != SFCM_IDLE);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Mode table: request-to-send source and transfer gating

  always_comb begin
    nxt_rts   = 1'b0;
    nxt_tx_en = 1'b1;
    nxt_rx_en = 1'b1;
    case (cfg_ff.mode)
      3'h0: begin
        // Pins ignored, both directions open
        nxt_rts = auto_rts;
      end
      3'h1: begin
        nxt_rts = sw_rts_ff;
      end
      3'h2: begin
        nxt_rts   = sw_rts_ff;
        nxt_tx_en = cts_s;
      end
      3'h3: begin
        nxt_rts = auto_rts || sw_rts_ff;
      end
      3'h4: begin
        // Far end answers the request with clear-to-send
        nxt_rts   = auto_rts || sw_rts_ff;
        nxt_tx_en = o_rts && cts_s;
        nxt_rx_en = cd_s;
      end
      3'h5: begin
        nxt_rts   = wm_rts_ff;
        nxt_tx_en = cts_s;
      end
      default: begin
        nxt_rts   = 1'b0;
        nxt_tx_en = 1'b0;
      end
    endcase
  end

  // Registered pin and gate outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rts       <= 1'b0;
      o_tx_enable <= 1'b0;
      o_rx_enable <= 1'b0;
    end else begin
      o_rts       <= nxt_rts;
      o_tx_enable <= nxt_tx_en;
      o_rx_enable <= nxt_rx_en;
    end
  end

  // Inhibit flags straight from configuration
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_inhibit_rxlen <= 1'b0;
      o_inhibit_tod   <= 1'b0;
    end else begin
      o_inhibit_rxlen <= cfg_ff.inh_rxlen;
      o_inhibit_tod   <= cfg_ff.inh_tod;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read path: data valid only in the cycle after the strobe, zero otherwise

  always_comb begin
    nxt_rdata = 32'h0;
    if (i_re) begin
      case (i_addr)
        `SFCM_OFF_CONFIG: begin
          nxt_rdata[`SFCM_EXT_LSB +: 8]    = cfg_ff.ext_cnt;
          nxt_rdata[`SFCM_UNIT_BIT]        = cfg_ff.ext_unit;
          nxt_rdata[`SFCM_INH_RXLEN_BIT]   = cfg_ff.inh_rxlen;
          nxt_rdata[`SFCM_INH_TOD_BIT]     = cfg_ff.inh_tod;
          nxt_rdata[`SFCM_MODE_LSB +: 3]   = cfg_ff.mode;
          nxt_rdata[`SFCM_CODE_LSB +: 8]   = `SFCM_CODE_OUTPUT;
        end
        `SFCM_OFF_STATUS: begin
          // External pin levels, whatever the mode does with them
          nxt_rdata[`SFCM_MODE_LSB +: 3]   = cfg_ff.mode;
          nxt_rdata[`SFCM_ST_CD_BIT]       = cd_s;
          nxt_rdata[`SFCM_ST_CTS_BIT]      = cts_s;
        end
        `SFCM_OFF_SWCMD: begin
          nxt_rdata[`SFCM_CMD_SET_BIT]     = sw_rts_ff;
          nxt_rdata[`SFCM_CMD_CLR_BIT]     = clr_pend_ff;
        end
        `SFCM_OFF_MARKS: begin
          nxt_rdata[`SFCM_HIGH_LSB +: 10]  = marks_ff.high;
          nxt_rdata[`SFCM_LOW_LSB +: 10]   = marks_ff.low;
          nxt_rdata[`SFCM_CODE_LSB +: 8]   = `SFCM_CODE_INPUT;
        end
        default: begin
          nxt_rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= nxt_rdata;
    end
  end

endmodule

// ===== src/sfcm_pkg.sv
// Purpose: Types shared by the serial flow control block
// Assumes: Constants come from sfcm_cfg.svh
// Notes:   Types only
package sfcm_pkg;

  // Flow configuration held by the block
  typedef struct packed {
    logic [7:0] ext_cnt;     // Turn-off extension in characters
    logic       ext_unit;    // 1 selects normalized 1200 bps characters
    logic       inh_rxlen;   // Blocks receive buffer length changes
    logic       inh_tod;     // Blocks transmit on demand
    logic [2:0] mode;        // Flow mode number
  } sfcm_cfg_type;

  // Receive watermarks for dynamic mode
  typedef struct packed {
    logic [9:0] high;
    logic [9:0] low;
  } sfcm_marks_type;

  // Automatic request-to-send sequencer
  typedef enum logic [1:0] {
    SFCM_IDLE,
    SFCM_SEND,
    SFCM_EXTEND
  } sfcm_state_type;

endpackage

// ===== tb/sfcm_dce_model.sv
// Purpose: Line-side partner of the flow block, a modem that answers request-to-send
// Assumes: Same clock as the block; answer delay picked by the bench
// Notes:   Carrier-detect level is steered by the bench; no pull-ups on these lines
module sfcm_dce_model (
  input  wire logic i_clk,    // Core clock
  input  wire logic i_rts,    // Request-to-send from the block
  input  wire logic i_slow,   // 1 answers after six cycles, 0 after one
  input  wire logic i_cd_on,  // Carrier present
  output logic      o_cts,    // Clear-to-send to the block
  output logic      o_cd      // Carrier-detect to the block
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [5:0] rts_dly_ff;  // Request history, newest in bit 0

  //////////////////////////////////////////////////////////////////////////////
  // Clear-to-send follows request-to-send with a modem delay; a slow answer
  // lets the bench see the block waiting before it sends
  always_ff @(posedge i_clk) begin
    rts_dly_ff <= {rts_dly_ff[4:0], i_rts};
  end

  assign o_cts = i_slow ? rts_dly_ff[5] : rts_dly_ff[0];
  assign o_cd  = i_cd_on;                                 // Carrier is a plain level
endmodule

// ===== tb/sfcm_flow_props.sv
// Purpose: Port-level checks of the serial flow control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Flow mode is tracked from register writes; attached by bind
`include "sfcm_cfg.svh"

module sfcm_flow_chk
  import sfcm_pkg::*;
#(
  parameter int unsigned NORM_CHAR_CYC = 8  // Cycles per normalized character
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_we,
  input wire logic        i_re,
  input wire logic [31:0] o_rdata,
  input wire logic        i_clear_to_send,
  input wire logic        i_carrier_detect,
  input wire logic        o_rts,
  input wire logic        i_tx_pending,
  input wire logic        i_tx_stop_done,
  input wire logic        i_char_tick,
  input wire logic [9:0]  i_rx_fill,
  input wire logic        o_tx_enable,
  input wire logic        o_rx_enable,
  input wire logic        o_inhibit_rxlen,
  input wire logic        o_inhibit_tod
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [2:0] mode_ff;  // Mode software expects; invalid numbers leave it alone

  //////////////////////////////////////////////////////////////////////////////
  // Mode tracker: a request command in mode 0 moves to manual mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_ff <= `SFCM_RST_MODE;
    end else if (i_we && i_addr == `SFCM_OFF_CONFIG && i_wdata[7:0] == `SFCM_CODE_OUTPUT
                 && i_wdata[10:8] <= `SFCM_MAX_MODE) begin
      mode_ff <= i_wdata[10:8];
    end else if (i_we && i_addr == `SFCM_OFF_SWCMD && i_wdata[1:0] != 2'h0 && mode_ff == 3'h0) begin
      mode_ff <= 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Steps of the multi-cycle behaviours
  sequence cfg_out_wr;
    i_we && i_addr == `SFCM_OFF_CONFIG && i_wdata[7:0] == `SFCM_CODE_OUTPUT;
  endsequence
  sequence mode0_send_req;
    (mode_ff == 3'h0) [*2] ##0 (i_tx_pending && !i_we);
  endsequence

  // Pins need three cycles to reach the enables, hence four quiet samples
  AST_RDATA_IDLE: assert property (!i_re |=> o_rdata == 32'h0)
    else $error("read data present without a read");
  AST_STATUS_FMT: assert property (i_re && i_addr == `SFCM_OFF_STATUS |=>
    o_rdata[31:11] == 21'h0 && o_rdata[10:8] == mode_ff) else $error("status word wrong");
  AST_FREE_XFER: assert property ((mode_ff inside {3'h0, 3'h1, 3'h3}) [*3] |->
    o_tx_enable && o_rx_enable) else $error("transfer blocked in a free mode");
  AST_SW_RTS: assert property ((mode_ff inside {3'h1, 3'h2} && !i_we) [*3] |-> $stable(o_rts))
    else $error("request-to-send moved without software");
  AST_CTS_GATE: assert property ((mode_ff inside {3'h2, 3'h5} && !i_clear_to_send) [*4] |->
    !o_tx_enable) else $error("sending without clear-to-send");
  AST_CD_GATE: assert property ((mode_ff == 3'h4 && !i_carrier_detect) [*4] |-> !o_rx_enable)
    else $error("receiving without carrier");
  AST_M4_WAIT: assert property ((mode_ff == 3'h4) [*3] ##0 o_tx_enable |-> $past(o_rts))
    else $error("sending without request-to-send");
  AST_AUTO_RAISE: assert property (mode0_send_req |-> ##[1:2] o_rts)
    else $error("request-to-send not raised for transmit");
  AST_INHIBIT: assert property (cfg_out_wr |-> ##2 (o_inhibit_tod == $past(i_wdata[11], 2)
    && o_inhibit_rxlen == $past(i_wdata[12], 2))) else $error("inhibit outputs wrong");
endmodule

bind sfcm_flow sfcm_flow_chk #(.NORM_CHAR_CYC(NORM_CHAR_CYC)) u_flow_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
  .o_rdata(o_rdata), .i_clear_to_send(i_clear_to_send), .i_carrier_detect(i_carrier_detect),
  .o_rts(o_rts), .i_tx_pending(i_tx_pending), .i_tx_stop_done(i_tx_stop_done), .i_char_tick(i_char_tick),
  .i_rx_fill(i_rx_fill), .o_tx_enable(o_tx_enable), .o_rx_enable(o_rx_enable),
  .o_inhibit_rxlen(o_inhibit_rxlen), .o_inhibit_tod(o_inhibit_tod));

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the serial flow control block with a modem partner
// Assumes: 125 MHz clock, short normalized character for simulation
// Notes:   Register tasks follow the one-cycle strobe protocol
`include "sfcm_cfg.svh"

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned NCC = 8;  // Short normalized character keeps runs brief
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_we = 1'b0, i_re = 1'b0, cts, cd, o_rts;
  logic i_tx_pending = 1'b0, i_tx_stop_done = 1'b0, i_char_tick = 1'b0, slow = 1'b0, cd_on = 1'b0;
  logic tx_en, rx_en, inh_rxlen, inh_tod;
  logic [3:0]  i_addr  = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, v;
  logic [9:0]  i_rx_fill = 10'h0;
  int mismatches = 0, cmp_count = 0, cycles = 0;

  always #4 i_clk = ~i_clk;  // 8 ns period

  sfcm_flow #(.NORM_CHAR_CYC(NCC)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_clear_to_send(cts),
    .i_carrier_detect(cd), .o_rts(o_rts), .i_tx_pending(i_tx_pending), .i_tx_stop_done(i_tx_stop_done),
    .i_char_tick(i_char_tick), .i_rx_fill(i_rx_fill), .o_tx_enable(tx_en), .o_rx_enable(rx_en),
    .o_inhibit_rxlen(inh_rxlen), .o_inhibit_tod(inh_tod));
  sfcm_dce_model u_dce (.i_clk(i_clk), .i_rts(o_rts), .i_slow(slow), .i_cd_on(cd_on), .o_cts(cts), .o_cd(cd));

  //////////////////////////////////////////////////////////////////////////////
  // Register port and timing helpers
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1 d = o_rdata;  // Data stand only in this cycle
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // End of frame: buffer empties as the last stop bit leaves
  task automatic frame_end();
    @(posedge i_clk);
    i_tx_pending <= 1'b0;
    i_tx_stop_done <= 1'b1;
    @(posedge i_clk);
    i_tx_stop_done <= 1'b0;
  endtask

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(`SFCM_OFF_CONFIG, v); `CHK(v, 32'h0100_0023)
    rd(`SFCM_OFF_MARKS, v); `CHK(v, 32'h4010_0022)
    rd(4'h6, v); `CHK(v, 32'h0)
    // Mode 0: automatic request, one character of extension at line rate
    @(posedge i_clk) i_tx_pending <= 1'b1;
    wt(4); `CHK({o_rts, tx_en, rx_en}, 3'b111)
    frame_end();
    wt(6); `CHK(o_rts, 1'b1)
    @(posedge i_clk) i_char_tick <= 1'b1;
    @(posedge i_clk) i_char_tick <= 1'b0;
    wt(4); `CHK(o_rts, 1'b0)
    // Normalized unit: two characters of eight cycles, ticks not used
    wr(`SFCM_OFF_CONFIG, 32'h0200_8023);
    @(posedge i_clk) i_tx_pending <= 1'b1;
    wt(4);
    frame_end();
    wt(10); `CHK(o_rts, 1'b1)
    wt(12); `CHK(o_rts, 1'b0)
    // Request command leaves mode 0 for manual mode
    wr(`SFCM_OFF_SWCMD, 32'h1);
    wt(6); `CHK(o_rts, 1'b1)
    rd(`SFCM_OFF_STATUS, v); `CHK({v[10:8], v[1:0]}, 5'b001_01)
    @(posedge i_clk) i_tx_pending <= 1'b1;
    wr(`SFCM_OFF_SWCMD, 32'h2);
    wt(6); `CHK({o_rts, tx_en}, 2'b01)
    // The sequencer is still in send and owes a frame end; its two normalized
    // characters of extension must run out before an automatic mode is chosen
    frame_end();
    wt(4); `CHK(o_rts, 1'b0)
    wt(16);
    // Mode 2: sending waits on the pin, request stays with software
    wr(`SFCM_OFF_CONFIG, 32'h0000_0223);
    wt(6); `CHK({tx_en, rx_en}, 2'b01)
    wr(`SFCM_OFF_SWCMD, 32'h1);
    wt(6); `CHK(tx_en, 1'b1)
    wr(`SFCM_OFF_SWCMD, 32'h2);
    // Mode 4 with a slow modem: carrier gates receive, send waits for clear
    slow <= 1'b1;
    wr(`SFCM_OFF_CONFIG, 32'h0000_0423);
    wt(8); `CHK(rx_en, 1'b0)
    @(posedge i_clk) cd_on <= 1'b1;
    wt(6); `CHK(rx_en, 1'b1)
    @(posedge i_clk) i_tx_pending <= 1'b1;
    wt(4); `CHK({o_rts, tx_en}, 2'b10)
    wt(10); `CHK(tx_en, 1'b1)
    wr(`SFCM_OFF_SWCMD, 32'h1);
    wr(`SFCM_OFF_SWCMD, 32'h2);
    rd(`SFCM_OFF_SWCMD, v); `CHK(v[1:0], 2'b11)
    frame_end();
    wt(6); `CHK(o_rts, 1'b0)
    // Mode 3: free transfer, software request clears at once when empty
    @(posedge i_clk) cd_on <= 1'b0;
    wr(`SFCM_OFF_CONFIG, 32'h0000_0323);
    wt(8); `CHK({o_rts, tx_en, rx_en}, 3'b011)
    wr(`SFCM_OFF_SWCMD, 32'h1);
    wt(4); `CHK(o_rts, 1'b1)
    wr(`SFCM_OFF_SWCMD, 32'h2);
    wt(4); `CHK(o_rts, 1'b0)
    // Mode 5: watermarks high 20, low 10
    wr(`SFCM_OFF_CONFIG, 32'h0500_a022);
    rd(`SFCM_OFF_MARKS, v); `CHK(v, 32'h0500_a022)
    @(posedge i_clk) i_rx_fill <= 10'd30;
    wr(`SFCM_OFF_CONFIG, 32'h0000_0523);
    wt(4); `CHK(o_rts, 1'b0)
    @(posedge i_clk) i_rx_fill <= 10'd15;
    wt(4); `CHK(o_rts, 1'b0)
    @(posedge i_clk) i_rx_fill <= 10'd5;
    wt(4); `CHK(o_rts, 1'b1)
    wt(12); `CHK(tx_en, 1'b1)
    // Invalid mode number is dropped, the inhibit bits still load
    wr(`SFCM_OFF_CONFIG, 32'h0000_1e23);
    rd(`SFCM_OFF_CONFIG, v); `CHK(v, 32'h0000_1d23)
    wt(2); `CHK({inh_rxlen, inh_tod}, 2'b11)
    conclude();
  end
endmodule
